// file: hdl/ep_ctrl_pkg.sv
// Constants for the endpoint handshake control block.
// Assumes a 32-bit AXI4-Lite master and a protocol engine on the same clock.
package ep_ctrl_pkg;
  // Register map; printed offsets are not all multiples of four, so index times four
  localparam logic [7:0] EP_SELECT_IDX = 8'h0A;
  localparam logic [7:0] EP_CONTROL_IDX = 8'h0B;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
  localparam logic [7:0] SETUP_SHARED_WRITE_GUARD_IDX = 8'h22;
  localparam logic [9:0] EP_SELECT_ADDR = {EP_SELECT_IDX, 2'b00};
  localparam logic [9:0] EP_CONTROL_ADDR = {EP_CONTROL_IDX, 2'b00};
  localparam logic [9:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  localparam logic [9:0] SETUP_SHARED_WRITE_GUARD_ADDR = {SETUP_SHARED_WRITE_GUARD_IDX, 2'b00};
  localparam int ADDR_W = 10;
  localparam int EP_COUNT = 8;
  localparam int SEL_W = 3;
  // Endpoint control fields
  localparam int RX_STALL_BIT = 7;
  localparam int TX_STALL_BIT = 6;
  localparam int CTL_TYPE_BIT = 5;
  localparam int RX_SPM_BIT = 4;
  localparam int RX_ACCEPT_BIT = 3;
  localparam int RX_EP_EN_BIT = 2;
  localparam int TX_REL_BIT = 1;
  localparam int TX_EP_EN_BIT = 0;
  localparam logic [7:0] EP0_RESET = 8'h35;
  localparam logic [7:0] EPN_RESET = 8'h10;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // Token and handshake codes
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
  localparam logic [2:0] HS_NONE = 3'h0;
  localparam logic [2:0] HS_ACK = 3'h1;
  localparam logic [2:0] HS_NAK = 3'h2;
  localparam logic [2:0] HS_STALL = 3'h3;
  localparam logic [2:0] HS_DATA = 3'h4;
  // Interrupt status bits
  localparam int IRQ_STALL_SET = 0;
  localparam int IRQ_SETUP = 1;
  localparam int IRQ_STALLED = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hdl/ep_ctrl_slot.sv
// One endpoint's control register copy.
// Assumes writes and hardware stall setting come from the same clock domain.
`timescale 1ns/1ps
module ep_ctrl_slot #(
  parameter logic [7:0] RESET_VALUE = 8'h10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Software write
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic guard_i,
  // Hardware stall set
  input wire logic rx_stall_set_i,
  // State
  output logic [7:0] value_o
);
  typedef struct packed {
    logic [7:0] ctrl;
  } slot_state_t;
  slot_state_t st_reg;
  slot_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_i) begin
      st_next.ctrl = wdata_i;
      // transmit stall only written with guard
      if (!guard_i) begin
        st_next.ctrl[ep_ctrl_pkg::TX_STALL_BIT] = st_reg.ctrl[ep_ctrl_pkg::TX_STALL_BIT];
      end
    end
    if (rx_stall_set_i) begin
      st_next.ctrl[ep_ctrl_pkg::RX_STALL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{ctrl: RESET_VALUE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign value_o = st_reg.ctrl;
endmodule // ep_ctrl_slot

// file: hdl/ep_handshake_ctrl.sv
// Endpoint control registers and handshake selection for a USB device.
// Assumes a protocol engine on CLK_I presents decoded tokens as one-cycle pulses.
// Functional notes
// - Reset loads 35h endpoint zero, 10h others
// - One control copy per endpoint, selector-indexed
// - Receive stall answers OUT with STALL
// - Stall with setup pending answers NAK
// - Receive stall never blocks SETUP
// - Bad status stage sets receive stall
// - Transmit stall answers IN with STALL
// - SETUP accepted only on control endpoints
// - Single-packet mode limits FIFO to one on OUT, not on SETUP
// - Accept disabled: OUT gets NAK or STALL
// - Receive endpoint disabled: no response
// - Release clear NAKs IN, set sends
// - Transmit endpoint disabled: no IN response
// - Three-bit selector picks endpoint 0-7
`timescale 1ns/1ps
module ep_handshake_ctrl (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // AXI4-Lite write address
  input wire logic [9:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire logic [9:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Token from protocol engine
  input wire logic TOKEN_VALID_I,
  input wire logic [1:0] TOKEN_KIND_I,
  input wire logic [2:0] TOKEN_EP_I,
  input wire logic STATUS_BAD_I,
  input wire logic RX_PACKETS_HELD_I,
  // Handshake decision
  output logic HS_VALID_O,
  output logic [2:0] HS_CODE_O,
  output logic RX_WRITE_EN_O,
  output logic SHARED_WRITE_GUARD_O,
  // Interrupt
  output logic IRQ_O
);
  typedef struct packed {
    logic aw_held;
    logic [9:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [2:0] selector;
    logic guard;
    logic [7:0] setup_shared_write_guard;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic hs_valid;
    logic [2:0] hs_code;
    logic rx_write;
  } top_state_t;
  top_state_t st_reg;
  top_state_t st_next;

  logic [7:0] ctrl [ep_ctrl_pkg::EP_COUNT];
  logic [7:0] slot_wr;
  logic [7:0] slot_stall;
  logic [7:0] tok_ctrl;
  logic [7:0] sel_ctrl;
  logic do_write;
  logic do_read;
  logic [2:0] hs;
  logic accept_rx;
  logic tok_setup_ok;
  logic set_stall_event;
  logic stalled_event;
  logic shared_write_guard;

  ////////////////////////////////////////////////////////////////////////////
  // one register copy per endpoint
  genvar g;
  generate
    for (g = 0; g < ep_ctrl_pkg::EP_COUNT; g++) begin : g_slot
      ep_ctrl_slot #(
        .RESET_VALUE(g == 0 ? ep_ctrl_pkg::EP0_RESET : ep_ctrl_pkg::EPN_RESET)
      ) u_slot (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .wr_i(slot_wr[g]),
        .wdata_i(st_reg.w_data[7:0]),
        .guard_i(st_reg.guard),
        .rx_stall_set_i(slot_stall[g]),
        .value_o(ctrl[g])
      );
      assign slot_wr[g] = do_write && st_reg.aw_addr == ep_ctrl_pkg::EP_CONTROL_ADDR
        && st_reg.w_strb[0] && st_reg.selector == 3'(g);
      // bad status stage on an OUT token, any endpoint
      assign slot_stall[g] = TOKEN_VALID_I && STATUS_BAD_I && TOKEN_EP_I == 3'(g)
        && TOKEN_KIND_I == ep_ctrl_pkg::TOK_OUT;
    end
  endgenerate

  assign sel_ctrl = ctrl[st_reg.selector];
  assign tok_ctrl = ctrl[TOKEN_EP_I];
  assign shared_write_guard = st_reg.setup_shared_write_guard[TOKEN_EP_I];

  ////////////////////////////////////////////////////////////////////////////
  // Handshake selection
  always_comb begin
    hs = ep_ctrl_pkg::HS_NONE;
    accept_rx = 1'b0;
    tok_setup_ok = 1'b0;
    unique case (TOKEN_KIND_I)
      ep_ctrl_pkg::TOK_OUT: begin
        if (!tok_ctrl[ep_ctrl_pkg::RX_EP_EN_BIT]) begin
          hs = ep_ctrl_pkg::HS_NONE;
        // pending setup turns stall into NAK
        end else if (tok_ctrl[ep_ctrl_pkg::RX_STALL_BIT] && shared_write_guard) begin
          hs = ep_ctrl_pkg::HS_NAK;
        end else if (tok_ctrl[ep_ctrl_pkg::RX_STALL_BIT]) begin
          hs = ep_ctrl_pkg::HS_STALL;
        end else if (!tok_ctrl[ep_ctrl_pkg::RX_ACCEPT_BIT]) begin
          hs = ep_ctrl_pkg::HS_NAK;
        end else if (tok_ctrl[ep_ctrl_pkg::RX_SPM_BIT] && RX_PACKETS_HELD_I) begin
          hs = ep_ctrl_pkg::HS_NAK;
        end else begin
          hs = ep_ctrl_pkg::HS_ACK;
          accept_rx = 1'b1;
        end
      end
      ep_ctrl_pkg::TOK_IN: begin
        if (!tok_ctrl[ep_ctrl_pkg::TX_EP_EN_BIT]) begin
          hs = ep_ctrl_pkg::HS_NONE;
        // pending setup turns stall into NAK
        end else if (tok_ctrl[ep_ctrl_pkg::TX_STALL_BIT] && shared_write_guard) begin
          hs = ep_ctrl_pkg::HS_NAK;
        end else if (tok_ctrl[ep_ctrl_pkg::TX_STALL_BIT]) begin
          hs = ep_ctrl_pkg::HS_STALL;
        end else if (!tok_ctrl[ep_ctrl_pkg::TX_REL_BIT]) begin
          hs = ep_ctrl_pkg::HS_NAK;
        end else begin
          hs = ep_ctrl_pkg::HS_DATA;
        end
      end
      ep_ctrl_pkg::TOK_SETUP: begin
        // setup needs control type and endpoint enable only
        if (tok_ctrl[ep_ctrl_pkg::RX_EP_EN_BIT] && tok_ctrl[ep_ctrl_pkg::CTL_TYPE_BIT]) begin
          hs = ep_ctrl_pkg::HS_ACK;
          accept_rx = 1'b1;
          tok_setup_ok = 1'b1;
        end
      end
      default: begin
        hs = ep_ctrl_pkg::HS_NONE;
      end
    endcase
  end

  assign set_stall_event = |slot_stall;
  assign stalled_event = TOKEN_VALID_I && hs == ep_ctrl_pkg::HS_STALL;
  assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.b_valid;
  assign do_read = S_AXI_ARVALID_I && !st_reg.r_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.hs_valid = TOKEN_VALID_I;
    st_next.hs_code = TOKEN_VALID_I ? hs : ep_ctrl_pkg::HS_NONE;
    st_next.rx_write = TOKEN_VALID_I && accept_rx;
    if (S_AXI_AWVALID_I && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = S_AXI_WDATA_I;
      st_next.w_strb = S_AXI_WSTRB_I;
    end
    if (S_AXI_BREADY_I && st_reg.b_valid) begin
      st_next.b_valid = 1'b0;
    end
    if (S_AXI_RREADY_I && st_reg.r_valid) begin
      st_next.r_valid = 1'b0;
    end
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp = ep_ctrl_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        ep_ctrl_pkg::EP_SELECT_ADDR: begin
          if (st_reg.w_strb[0]) begin
            st_next.selector = st_reg.w_data[2:0];
          end
        end
        ep_ctrl_pkg::EP_CONTROL_ADDR: begin
          // guard bit rides in byte 1
          if (st_reg.w_strb[1]) begin
            st_next.guard = st_reg.w_data[8];
          end
        end
        ep_ctrl_pkg::IRQ_MASK_ADDR: begin
          if (st_reg.w_strb[0]) begin
            st_next.irq_mask = st_reg.w_data[2:0];
          end
        end
        ep_ctrl_pkg::SETUP_SHARED_WRITE_GUARD_ADDR: begin
          // Write one to clear a serviced setup
          if (st_reg.w_strb[0]) begin
            st_next.setup_shared_write_guard = st_reg.setup_shared_write_guard & ~st_reg.w_data[7:0];
          end
        end
        ep_ctrl_pkg::IRQ_STATUS_ADDR: begin
        end
        default: begin
          st_next.b_resp = ep_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (do_read) begin
      st_next.r_valid = 1'b1;
      st_next.r_resp = ep_ctrl_pkg::RESP_OKAY;
      st_next.r_data = 32'h0000_0000;
      unique case (S_AXI_ARADDR_I)
        ep_ctrl_pkg::EP_SELECT_ADDR: st_next.r_data = {29'h0000_0000, st_reg.selector};
        ep_ctrl_pkg::EP_CONTROL_ADDR: st_next.r_data = {23'h00_0000, st_reg.guard, sel_ctrl};
        ep_ctrl_pkg::IRQ_MASK_ADDR: st_next.r_data = {29'h0000_0000, st_reg.irq_mask};
        ep_ctrl_pkg::SETUP_SHARED_WRITE_GUARD_ADDR: st_next.r_data = {24'h00_0000, st_reg.setup_shared_write_guard};
        ep_ctrl_pkg::IRQ_STATUS_ADDR: begin
          st_next.r_data = {29'h0000_0000, st_reg.irq_status};
          st_next.irq_status = 3'h0;
        end
        default: st_next.r_resp = ep_ctrl_pkg::RESP_SLVERR;
      endcase
    end
    // setup pending until firmware services it; set wins over clear
    if (TOKEN_VALID_I && tok_setup_ok) begin
      st_next.setup_shared_write_guard[TOKEN_EP_I] = 1'b1;
    end
    if (set_stall_event) begin
      st_next.irq_status[ep_ctrl_pkg::IRQ_STALL_SET] = 1'b1;
    end
    if (TOKEN_VALID_I && tok_setup_ok) begin
      st_next.irq_status[ep_ctrl_pkg::IRQ_SETUP] = 1'b1;
    end
    if (stalled_event) begin
      st_next.irq_status[ep_ctrl_pkg::IRQ_STALLED] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign S_AXI_AWREADY_O = !st_reg.aw_held;
  assign S_AXI_WREADY_O = !st_reg.w_held;
  assign S_AXI_BVALID_O = st_reg.b_valid;
  assign S_AXI_BRESP_O = st_reg.b_resp;
  assign S_AXI_ARREADY_O = !st_reg.r_valid;
  assign S_AXI_RVALID_O = st_reg.r_valid;
  assign S_AXI_RDATA_O = st_reg.r_data;
  assign S_AXI_RRESP_O = st_reg.r_resp;
  assign HS_VALID_O = st_reg.hs_valid;
  assign HS_CODE_O = st_reg.hs_code;
  assign RX_WRITE_EN_O = st_reg.rx_write;
  assign SHARED_WRITE_GUARD_O = st_reg.guard;
  assign IRQ_O = |(st_reg.irq_status & st_reg.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_rx_disable_silent: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I != ep_ctrl_pkg::TOK_IN && !tok_ctrl[2]
    |=> HS_VALID_O && HS_CODE_O == ep_ctrl_pkg::HS_NONE)
    else $error("disabled receive endpoint answered");
  a_rx_stall_out: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_OUT && tok_ctrl[2] && tok_ctrl[7] && !shared_write_guard
    |=> HS_CODE_O == ep_ctrl_pkg::HS_STALL)
    else $error("OUT on stalled endpoint not stalled");
  a_stall_shared_write_guard_nak: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_IN && tok_ctrl[0] && tok_ctrl[6] && shared_write_guard
    |=> HS_CODE_O == ep_ctrl_pkg::HS_NAK)
    else $error("stall with setup pending not NAK");
  a_tx_stall_in: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_IN && tok_ctrl[0] && tok_ctrl[6] && !shared_write_guard
    |=> HS_CODE_O == ep_ctrl_pkg::HS_STALL)
    else $error("IN on stalled endpoint not stalled");
  a_setup_ctl_only: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_SETUP && !tok_ctrl[5]
    |=> !RX_WRITE_EN_O && HS_CODE_O == ep_ctrl_pkg::HS_NONE)
    else $error("setup taken on non-control endpoint");
  a_setup_despite_stall: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_SETUP && tok_ctrl[5] && tok_ctrl[2]
    |=> RX_WRITE_EN_O ##0 st_reg.setup_shared_write_guard[$past(TOKEN_EP_I)])
    else $error("setup refused on enabled control endpoint");
  a_accept_off_nak: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_OUT && tok_ctrl[2] && !tok_ctrl[7]
    && !tok_ctrl[3] |=> HS_CODE_O == ep_ctrl_pkg::HS_NAK && !RX_WRITE_EN_O)
    else $error("OUT with accept off not NAKed");
  a_tx_release: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_IN && tok_ctrl[0] && !tok_ctrl[6]
    |=> HS_CODE_O == ($past(tok_ctrl[1]) ? ep_ctrl_pkg::HS_DATA : ep_ctrl_pkg::HS_NAK))
    else $error("IN answer disagrees with release enable");
  a_tx_disable_silent: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_IN && !tok_ctrl[0]
    |=> HS_CODE_O == ep_ctrl_pkg::HS_NONE)
    else $error("disabled transmit endpoint answered");
  a_bad_status_stall: assert property (@(posedge CLK_I) disable iff (RST_I)
    slot_stall[TOKEN_EP_I] |=> ctrl[$past(TOKEN_EP_I)][7])
    else $error("bad status stage did not stall");
  a_single_packet: assert property (@(posedge CLK_I) disable iff (RST_I)
    TOKEN_VALID_I && TOKEN_KIND_I == ep_ctrl_pkg::TOK_OUT && tok_ctrl[4] && RX_PACKETS_HELD_I
    |=> !RX_WRITE_EN_O)
    else $error("second packet accepted in single-packet mode");
endmodule // ep_handshake_ctrl

// file: testbench/host_token_model.sv
// Token side of the USB host: issues decoded tokens and records the handshake.
// Assumes the design answers one cycle after each token pulse.
`timescale 1ns/1ps
module host_token_model (
  // Clock
  input wire logic clk_i,
  // Token out
  output logic token_valid_o,
  output logic [1:0] token_kind_o,
  output logic [2:0] token_ep_o,
  output logic status_bad_o,
  output logic held_o,
  // Handshake in
  input wire logic hs_valid_i,
  input wire logic [2:0] hs_code_i,
  input wire logic rx_wen_i
);
  initial begin
    token_valid_o = 1'b0;
    token_kind_o = 2'h3;
    token_ep_o = 3'h0;
    status_bad_o = 1'b0;
    held_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One token pulse; kind and endpoint lines show the inverse once released so stale data never matches
  task automatic send(input logic [1:0] k, input logic [2:0] e, input logic b, input logic h,
                      output logic v, output logic [2:0] c, output logic w);
    token_valid_o <= 1'b1;
    token_kind_o <= k;
    token_ep_o <= e;
    status_bad_o <= b;
    held_o <= h;
    @(posedge clk_i);
    token_valid_o <= 1'b0;
    token_kind_o <= ~k;
    token_ep_o <= ~e;
    status_bad_o <= 1'b0;
    #1;
    v = hs_valid_i;
    c = hs_code_i;
    w = rx_wen_i;
    @(posedge clk_i);
  endtask
endmodule // host_token_model

// file: testbench/endpoint_handshake_control_tb.sv
// Testbench: register access over AXI4-Lite and token sequences against handshakes.
// Assumes the design package constants and the host token model.
`timescale 1ns/1ps
module endpoint_handshake_control_tb;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, hs_valid, rx_wen, guard, irq;
  logic [1:0] bresp, rresp, resp, tok_kind;
  logic [2:0] hs_code, tok_ep, code;
  logic tok_valid, bad, held, v, wen;
  int miscompares, checks;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ep_handshake_ctrl u_ep_handshake_ctrl (.CLK_I(clk), .RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TOKEN_VALID_I(tok_valid),
    .TOKEN_KIND_I(tok_kind), .TOKEN_EP_I(tok_ep), .STATUS_BAD_I(bad),
    .RX_PACKETS_HELD_I(held), .HS_VALID_O(hs_valid), .HS_CODE_O(hs_code),
    .RX_WRITE_EN_O(rx_wen), .SHARED_WRITE_GUARD_O(guard), .IRQ_O(irq));
  host_token_model u_host_token_model (.clk_i(clk), .token_valid_o(tok_valid),
    .token_kind_o(tok_kind), .token_ep_o(tok_ep), .status_bad_o(bad), .held_o(held),
    .hs_valid_i(hs_valid), .hs_code_i(hs_code), .rx_wen_i(rx_wen));
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    int n;
    aw_done = 0;
    w_done = 0;
    r = 2'h3;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (!aw_done && awready) begin aw_done = 1; awvalid <= 1'b0; end
      if (!w_done && wready) begin w_done = 1; wvalid <= 1'b0; end
      if (bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
    if (n == 50) begin miscompares++; conclude(); end
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_done;
    int n;
    ar_done = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (!ar_done && arready) begin ar_done = 1; arvalid <= 1'b0; end
      if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
    end
    if (n == 50) begin miscompares++; conclude(); end
    @(posedge clk);
  endtask
  task automatic reg_wr(input logic [9:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
    check(resp, ep_ctrl_pkg::RESP_OKAY);
  endtask
  task automatic reg_rd(input logic [9:0] a);
    axi_rd(a, rd, resp);
    check(resp, ep_ctrl_pkg::RESP_OKAY);
  endtask
  // Token with a fixed expected handshake; one answer cycle each
  task automatic tok(input logic [1:0] k, input logic [2:0] e, input logic h,
                     input logic [2:0] exp);
    u_host_token_model.send(k, e, 1'b0, h, v, code, wen);
    check(v, 1);
    check(code, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 10'h000; araddr = 10'h000; wdata = 32'h0000_0000; wstrb = 4'h0;
    miscompares = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Every copy holds its own reset value
    for (int i = 0; i < 8; i++) begin
      reg_wr(ep_ctrl_pkg::EP_SELECT_ADDR, i);
      reg_rd(ep_ctrl_pkg::EP_CONTROL_ADDR);
      check(rd[7:0], i == 0 ? 8'h35 : 8'h10);
    end
    // Unmapped place is refused with zero data
    axi_rd(10'h3FC, rd, resp);
    check(rd, 32'h0000_0000);
    check(resp, ep_ctrl_pkg::RESP_SLVERR);
    axi_wr(10'h3FC, 32'h0000_0000, resp);
    check(resp, ep_ctrl_pkg::RESP_SLVERR);
    reg_wr(ep_ctrl_pkg::EP_SELECT_ADDR, 32'h0000_0000);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h0, 1'b0, ep_ctrl_pkg::HS_NAK);
    tok(ep_ctrl_pkg::TOK_IN, 3'h0, 1'b0, ep_ctrl_pkg::HS_NAK);
    tok(ep_ctrl_pkg::TOK_SETUP, 3'h0, 1'b0, ep_ctrl_pkg::HS_ACK);
    reg_wr(ep_ctrl_pkg::SETUP_SHARED_WRITE_GUARD_ADDR, 32'h0000_00FF);
    // Endpoint 1: enables one at a time
    reg_wr(ep_ctrl_pkg::EP_SELECT_ADDR, 32'h0000_0001);
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_000B);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h1, 1'b0, ep_ctrl_pkg::HS_NONE);
    tok(ep_ctrl_pkg::TOK_SETUP, 3'h1, 1'b0, ep_ctrl_pkg::HS_NONE);
    tok(ep_ctrl_pkg::TOK_IN, 3'h1, 1'b0, ep_ctrl_pkg::HS_DATA);
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_001C);
    tok(ep_ctrl_pkg::TOK_IN, 3'h1, 1'b0, ep_ctrl_pkg::HS_NONE);
    tok(ep_ctrl_pkg::TOK_SETUP, 3'h1, 1'b0, ep_ctrl_pkg::HS_NONE);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h1, 1'b0, ep_ctrl_pkg::HS_ACK);
    check(wen, 1);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h1, 1'b1, ep_ctrl_pkg::HS_NAK);
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_0084);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h1, 1'b0, ep_ctrl_pkg::HS_STALL);
    // Endpoint 0: stalls against a pending setup
    reg_wr(ep_ctrl_pkg::EP_SELECT_ADDR, 32'h0000_0000);
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_00B5);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h0, 1'b0, ep_ctrl_pkg::HS_STALL);
    tok(ep_ctrl_pkg::TOK_SETUP, 3'h0, 1'b0, ep_ctrl_pkg::HS_ACK);
    tok(ep_ctrl_pkg::TOK_OUT, 3'h0, 1'b0, ep_ctrl_pkg::HS_NAK);
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_01B5);
    check(guard, 1);
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_01F5);
    reg_rd(ep_ctrl_pkg::EP_CONTROL_ADDR);
    check(rd[7:0], 8'hF5);
    tok(ep_ctrl_pkg::TOK_IN, 3'h0, 1'b0, ep_ctrl_pkg::HS_NAK);
    reg_wr(ep_ctrl_pkg::SETUP_SHARED_WRITE_GUARD_ADDR, 32'h0000_00FF);
    tok(ep_ctrl_pkg::TOK_IN, 3'h0, 1'b0, ep_ctrl_pkg::HS_STALL);
    // Sticky status: setup seen and STALL sent, cleared by the read
    reg_rd(ep_ctrl_pkg::IRQ_STATUS_ADDR);
    check(rd, 32'h0000_0006);
    reg_rd(ep_ctrl_pkg::IRQ_STATUS_ADDR);
    check(rd, 32'h0000_0000);
    // Interrupt masked, raised, cleared
    reg_wr(ep_ctrl_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
    tok(ep_ctrl_pkg::TOK_IN, 3'h0, 1'b0, ep_ctrl_pkg::HS_STALL);
    check(irq, 0);
    reg_wr(ep_ctrl_pkg::IRQ_MASK_ADDR, 32'h0000_0004);
    check(irq, 1);
    reg_rd(ep_ctrl_pkg::IRQ_STATUS_ADDR);
    check(irq, 0);
    @(posedge clk);
    // Setup was serviced, so firmware may now lift both stalls
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_0035);
    tok(ep_ctrl_pkg::TOK_IN, 3'h0, 1'b0, ep_ctrl_pkg::HS_NAK);
    // Bad status stage makes the hardware set the receive stall
    reg_wr(ep_ctrl_pkg::EP_CONTROL_ADDR, 32'h0000_003D);
    u_host_token_model.send(ep_ctrl_pkg::TOK_OUT, 3'h0, 1'b1, 1'b0, v, code, wen);
    reg_rd(ep_ctrl_pkg::EP_CONTROL_ADDR);
    check(rd[7:0], 8'hBD);
    reg_rd(ep_ctrl_pkg::IRQ_STATUS_ADDR);
    check(rd[0], 1);
    conclude();
  end
endmodule // endpoint_handshake_control_tb
